// [verilog/ea_modulo_unit.sv]
// Purpose: effective address generation with circular buffer correction
// Assumes: decoder presents one request per cycle with register values read
// Notes: results appear one cycle after the request; valid, fault, enables and dest_reg last one cycle
`timescale 1ns/10ps
`include "ea_unit_defs.svh"
module ea_modulo_unit
	import ea_unit_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic [31:0] haddr,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic req,
	input wire op_class_t op_class,
	input wire addr_mode_t a_mode,
	input wire logic [3:0] a_idx,
	input wire logic [15:0] a_ptr,
	input wire addr_mode_t b_mode,
	input wire logic [3:0] b_idx,
	input wire logic [15:0] b_ptr,
	input wire logic [15:0] off_val,
	input wire logic [15:0] lit,
	input wire logic [15:0] step,
	input wire logic [1:0] mac_step,
	input wire logic file_to_default_working_register,
	output logic valid,
	output logic fault,
	output logic [15:0] ea_a,
	output logic [15:0] ea_b,
	output logic wa_en,
	output logic [15:0] wa_val,
	output logic wb_en,
	output logic [15:0] wb_val,
	output logic dest_reg,
	output logic [15:0] opnd
);
	core_st_t st_r;
	core_st_t st_nxt;
	logic [15:0] ctrl;
	logic [15:0] xs;
	logic [15:0] xe;
	logic [15:0] ys;
	logic [15:0] ye;
	logic [15:0] stp;
	logic [15:0] d_a;
	logic [15:0] d_b;
	logic [15:0] sum_a;
	logic [15:0] sum_b;
	logic [15:0] cor_a;
	logic [15:0] cor_b;
	logic mod_a;
	logic mod_b;
	logic b_y;
	logic x_on;
	logic y_on;

	// hsize is accepted but only whole words are ever moved
	ea_regs u_regs (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.hsel(hsel),
		.htrans(htrans),
		.haddr(haddr),
		.hwrite(hwrite),
		.hwdata(hwdata),
		.hready(hready),
		.last_ea(st_r.ea_a),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.ctrl(ctrl),
		.xs(xs),
		.xe(xe),
		.ys(ys),
		.ye(ye)
	);

	// mac step code to byte count, zero marks an illegal code
	function automatic logic [15:0] mac_step_val(input logic [1:0] c);
		case (c)
			2'h1: mac_step_val = `MAC_STEP_2;
			2'h2: mac_step_val = `MAC_STEP_4;
			2'h3: mac_step_val = `MAC_STEP_6;
			default: mac_step_val = 16'h0000;
		endcase
	endfunction

	// what a mode adds to its pointer before correction
	function automatic logic [15:0] delta_of(input addr_mode_t m, input logic [15:0] s);
		case (m)
			AM_POST, AM_PRE: delta_of = s;
			AM_INDEX: delta_of = off_val;
			AM_LITOFF: delta_of = lit;
			default: delta_of = 16'h0000;
		endcase
	endfunction

	// modulo enables: one buffer per space, a select of 15 parks it
	assign x_on = ctrl[`XEN_BIT] && ctrl[`XSEL_LSB +: 4] != `SEL_OFF;
	assign y_on = ctrl[`YEN_BIT] && ctrl[`YSEL_LSB +: 4] != `SEL_OFF;
	assign b_y = op_class == CLS_MAC;
	assign mod_a = x_on && a_idx == ctrl[`XSEL_LSB +: 4];
	assign mod_b = b_y ? (y_on && b_idx == ctrl[`YSEL_LSB +: 4])
		: (x_on && b_idx == ctrl[`XSEL_LSB +: 4]);
	assign stp = (op_class == CLS_MAC) ? mac_step_val(mac_step) : step;
	assign d_a = delta_of(a_mode, stp);
	assign d_b = delta_of(b_mode, stp);
	assign sum_a = a_ptr + d_a;
	assign sum_b = b_ptr + d_b;

	// x generator serves move sources and mac x reads
	circ_correct u_cor_a (
		.en(mod_a),
		.up(!d_a[15]),
		.lo(xs),
		.hi(xe),
		.sum(sum_a),
		.addr(cor_a)
	);

	// second generator is y space only for mac reads
	circ_correct u_cor_b (
		.en(mod_b),
		.up(!d_b[15]),
		.lo(b_y ? ys : xs),
		.hi(b_y ? ye : xe),
		.sum(sum_b),
		.addr(cor_b)
	);

	// request decode; valid, fault, enables and dest_reg live one cycle, addresses, values and opnd hold
	always_comb begin
		st_nxt = st_r;
		st_nxt.valid = req;
		st_nxt.fault = 1'b0;
		st_nxt.wa_en = 1'b0;
		st_nxt.wb_en = 1'b0;
		st_nxt.dest_reg = 1'b0;
		if (req) begin
			st_nxt.ea_a = (a_mode == AM_IND || a_mode == AM_POST) ? a_ptr : cor_a;
			st_nxt.ea_b = (b_mode == AM_IND || b_mode == AM_POST) ? b_ptr : cor_b;
			st_nxt.wa_val = cor_a;
			st_nxt.wb_val = cor_b;
			// only stepping modes touch the pointer
			st_nxt.wa_en = a_mode == AM_POST || a_mode == AM_PRE;
			st_nxt.wb_en = b_mode == AM_POST || b_mode == AM_PRE;
			st_nxt.opnd = (a_mode == AM_LIT) ? lit : a_ptr;
			case (op_class)
				CLS_FILE: begin
					st_nxt.ea_a = {3'h0, lit[`NEAR_BITS-1:0]};
					st_nxt.ea_b = {12'h000, `DEFAULT_WORKING_REGISTER_IDX};
					st_nxt.dest_reg = file_to_default_working_register;
					st_nxt.wa_en = 1'b0;
					st_nxt.wb_en = 1'b0;
				end
				CLS_MCU: begin
					// operand one comes straight from a register
					if (b_mode != AM_DIRECT || a_mode == AM_INDEX || a_mode == AM_LITOFF) begin
						st_nxt.fault = 1'b1;
					end
					if (a_mode == AM_LIT) begin
						st_nxt.opnd = {11'h000, lit[4:0]};
					end
					st_nxt.wb_en = 1'b0;
				end
				CLS_MOVE: begin
					st_nxt.fault = 1'b0;
				end
				CLS_MAC: begin
					// restricted pointer set keeps x and y ports apart
					if ((a_idx != `MAC_X_A && a_idx != `MAC_X_B)
							|| (b_idx != `MAC_Y_A && b_idx != `MAC_Y_B)) begin
						st_nxt.fault = 1'b1;
					end
					if ((a_mode == AM_INDEX && a_idx != `MAC_X_B)
							|| (b_mode == AM_INDEX && b_idx != `MAC_Y_B)) begin
						st_nxt.fault = 1'b1;
					end
					if (a_mode != AM_IND && a_mode != AM_POST && a_mode != AM_INDEX) begin
						st_nxt.fault = 1'b1;
					end
					if (b_mode != AM_IND && b_mode != AM_POST && b_mode != AM_INDEX) begin
						st_nxt.fault = 1'b1;
					end
					if ((a_mode == AM_POST || b_mode == AM_POST) && mac_step == 2'h0) begin
						st_nxt.fault = 1'b1;
					end
				end
				CLS_BRA: begin
					st_nxt.opnd = lit;
					st_nxt.wa_en = 1'b0;
					st_nxt.wb_en = 1'b0;
				end
				CLS_INTERRUPT_DISABLE_OPERATION: begin
					st_nxt.opnd = {2'h0, lit[13:0]};
					st_nxt.wa_en = 1'b0;
					st_nxt.wb_en = 1'b0;
				end
				default: begin
					st_nxt.fault = 1'b1;
				end
			endcase
			// a refused request must not corrupt any pointer
			if (st_nxt.fault) begin
				st_nxt.wa_en = 1'b0;
				st_nxt.wb_en = 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign valid = st_r.valid;
	assign fault = st_r.fault;
	assign ea_a = st_r.ea_a;
	assign ea_b = st_r.ea_b;
	assign wa_en = st_r.wa_en;
	assign wa_val = st_r.wa_val;
	assign wb_en = st_r.wb_en;
	assign wb_val = st_r.wb_val;
	assign dest_reg = st_r.dest_reg;
	assign opnd = st_r.opnd;

	// checks on the request to result relation
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_file_near:
	assert property (ce && req && op_class == CLS_FILE |=> ea_a == {3'h0, $past(lit[12:0])})
		else $error("file address not taken from near field");
	a_file_default_working_register:
	assert property (ce && req && op_class == CLS_FILE |=> dest_reg == $past(file_to_default_working_register)
		&& ea_b == 16'h0000 && !wa_en) else $error("file result register wrong");
	a_mcu_direct:
	assert property (ce && req && op_class == CLS_MCU && b_mode != AM_DIRECT |=> fault && !wa_en)
		else $error("mcu operand one not refused");
	a_ind_plain:
	assert property (ce && req && op_class == CLS_MOVE && a_mode == AM_IND
		|=> ea_a == $past(a_ptr) && !wa_en) else $error("indirect address altered");
	a_post_step:
	assert property (ce && req && op_class == CLS_MOVE && a_mode == AM_POST && !mod_a
		|=> ea_a == $past(a_ptr) && wa_en && wa_val == $past(a_ptr) + $past(step))
		else $error("post modify wrong");
	a_pre_step:
	assert property (ce && req && op_class == CLS_MOVE && a_mode == AM_PRE && !mod_a
		|=> wa_en && ea_a == wa_val && ea_a == $past(a_ptr) + $past(step))
		else $error("pre modify wrong");
	a_index_sum:
	assert property (ce && req && op_class == CLS_MOVE && b_mode == AM_INDEX && !mod_b
		|=> ea_b == $past(b_ptr) + $past(off_val) && !wb_en) else $error("indexed sum wrong");
	a_mac_ptrs:
	assert property (ce && req && op_class == CLS_MAC && a_idx != `MAC_X_A
		&& a_idx != `MAC_X_B |=> fault) else $error("mac x pointer outside set accepted");
	a_mac_index:
	assert property (ce && req && op_class == CLS_MAC && a_mode == AM_INDEX
		&& a_idx == `MAC_X_A |=> fault) else $error("mac index on wrong pointer");
	a_mac_step:
	assert property (ce && req && op_class == CLS_MAC && a_idx == `MAC_X_A && b_idx == `MAC_Y_A
		&& a_mode == AM_POST && b_mode == AM_IND && mac_step == 2'h3 && !mod_a
		|=> !fault && wa_val == ea_a + 16'h0006) else $error("mac step of six wrong");
	a_interrupt_disable_operation_cnt:
	assert property (ce && req && op_class == CLS_INTERRUPT_DISABLE_OPERATION |=> opnd[15:14] == 2'h0
		&& opnd[13:0] == $past(lit[13:0])) else $error("disable count wrong");
	a_xmod_off:
	assert property (ce && ctrl[3:0] == 4'hf |-> !mod_a) else $error("x modulo with select 15");
	a_offset_keep:
	assert property (ce && req && op_class == CLS_MOVE && a_mode == AM_LITOFF |=> !wa_en
		&& ea_a == $past(cor_a)) else $error("offset mode wrote pointer");
	a_wrap_up:
	assert property (ce && req && mod_a && a_mode == AM_PRE && !d_a[15] && sum_a == xe + 16'h0001
		&& xe >= xs |=> ea_a == $past(xs)) else $error("upper wrap not to start");

	c_post_wrap: cover property (ce && req && mod_a && a_mode == AM_POST && cor_a != sum_a);
	c_mac_ok: cover property (ce && req && op_class == CLS_MAC ##1 valid && !fault);
	c_move_both: cover property (ce && req && op_class == CLS_MOVE && a_mode == AM_POST
		&& b_mode == AM_PRE);
endmodule

// [include/ea_unit_defs.svh]
// Purpose: constants for the effective address and circular buffer unit
// Assumes: byte addresses, 16-bit data words, 32-bit bus words
// Notes: register offsets are bus byte addresses
// Contract
// - file address is 13-bit near field
// - file results go to working register zero
// - operand one is register direct only
// - indirect uses pointer unchanged as address
// - post-modify uses old pointer, writes stepped
// - pre-modify steps pointer, then uses it
// - indexed address is base plus offset register
// - literal offset address is pointer plus literal
// - move source and destination share offset field
// - mac pointers eight-nine x, ten-eleven y
// - mac indexing only on nine and eleven
// - mac steps are two, four or six
// - branch 16-bit signed, disable count 14-bit
// - one circular buffer in x, one in y
// - power-of-two buffers checked at both ends
// - buffer bounds are 16-bit start and end
// - buffers up to 32K words long
// - x modulo needs select not 15, bit 15
// - y modulo needs select not 15, bit 14
// - boundary check catches overshoot, not equality
// - offset modes correct address, keep pointer
`ifndef EA_UNIT_DEFS_SVH
`define EA_UNIT_DEFS_SVH
`define OFS_CTRL 8'h00
`define OFS_XSTART 8'h04
`define OFS_XEND 8'h08
`define OFS_YSTART 8'h0c
`define OFS_YEND 8'h10
`define OFS_LAST_EA 8'h14
`define CTRL_RESET 16'h00ff
`define BOUND_RESET 16'h0000
`define XSEL_LSB 0
`define YSEL_LSB 4
`define XEN_BIT 15
`define YEN_BIT 14
`define SEL_OFF 4'hf
`define DEFAULT_WORKING_REGISTER_IDX 4'h0
`define NEAR_BITS 13
`define MAC_X_A 4'h8
`define MAC_X_B 4'h9
`define MAC_Y_A 4'ha
`define MAC_Y_B 4'hb
`define MAC_STEP_2 16'h0002
`define MAC_STEP_4 16'h0004
`define MAC_STEP_6 16'h0006
`endif

// [include/ea_unit_pkg.sv]
// Purpose: types shared by the address unit files
// Assumes: constants live in ea_unit_defs.svh
// Notes: state of each module is one packed struct
package ea_unit_pkg;
	typedef enum logic [2:0] {CLS_FILE, CLS_MCU, CLS_MOVE, CLS_MAC, CLS_BRA, CLS_INTERRUPT_DISABLE_OPERATION} op_class_t;
	typedef enum logic [2:0] {AM_DIRECT, AM_IND, AM_POST, AM_PRE, AM_INDEX, AM_LITOFF, AM_LIT} addr_mode_t;
	typedef struct packed {
		logic valid;
		logic fault;
		logic [15:0] ea_a;
		logic [15:0] ea_b;
		logic wa_en;
		logic [15:0] wa_val;
		logic wb_en;
		logic [15:0] wb_val;
		logic dest_reg;
		logic [15:0] opnd;
	} core_st_t;
	typedef struct packed {
		logic wr_pend;
		logic [7:0] wofs;
		logic [15:0] ctrl;
		logic [15:0] xs;
		logic [15:0] xe;
		logic [15:0] ys;
		logic [15:0] ye;
		logic [31:0] rdata;
		logic rdy;
	} regs_st_t;
endpackage

// [verilog/circ_correct.sv]
// Purpose: circular buffer address correction for one generator
// Assumes: bounds are inclusive byte addresses, end >= start
// Notes: purely combinational
`timescale 1ns/10ps
module circ_correct
	import ea_unit_pkg::*;
(
	input wire logic en,
	input wire logic up,
	input wire logic [15:0] lo,
	input wire logic [15:0] hi,
	input wire logic [15:0] sum,
	output logic [15:0] addr
);
	logic [16:0] len;
	logic pow2;
	logic over_hi;
	logic under_lo;

	// length implied by the bounds, 17 bits so 64 Kbytes fits
	always_comb begin
		len = {1'b0, hi} - {1'b0, lo} + 17'h00001;
		pow2 = (len & (len - 17'h00001)) == 17'h00000;
		// other lengths only watch the edge they run toward
		over_hi = en && (pow2 || up) && (sum > hi);
		under_lo = en && (pow2 || !up) && (sum < lo);
		if (over_hi) begin
			addr = lo + (sum - hi - 16'h0001);
		end else if (under_lo) begin
			addr = hi - (lo - sum - 16'h0001);
		end else begin
			addr = sum;
		end
	end
endmodule

// [verilog/ea_regs.sv]
// Purpose: AHB-Lite slave holding modulo control and buffer bounds
// Assumes: single word transfers, zero wait states
// Notes: unmapped offsets read zero and ignore writes
`timescale 1ns/10ps
`include "ea_unit_defs.svh"
module ea_regs
	import ea_unit_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic [31:0] haddr,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [15:0] last_ea,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [15:0] ctrl,
	output logic [15:0] xs,
	output logic [15:0] xe,
	output logic [15:0] ys,
	output logic [15:0] ye
);
	regs_st_t st_r;
	regs_st_t st_nxt;
	logic take;

	// read mux, shared by the address phase and write forwarding
	function automatic logic [15:0] rd_val(input regs_st_t s, input logic [7:0] o,
			input logic [15:0] ea);
		case (o)
			`OFS_CTRL: rd_val = s.ctrl;
			`OFS_XSTART: rd_val = s.xs;
			`OFS_XEND: rd_val = s.xe;
			`OFS_YSTART: rd_val = s.ys;
			`OFS_YEND: rd_val = s.ye;
			`OFS_LAST_EA: rd_val = ea;
			default: rd_val = 16'h0000;
		endcase
	endfunction

	assign take = hsel && hready && htrans[1];

	// data phase write first, so a read right behind it sees new data
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdy = 1'b1;
		if (st_r.wr_pend) begin
			case (st_r.wofs)
				`OFS_CTRL: st_nxt.ctrl = hwdata[15:0];
				`OFS_XSTART: st_nxt.xs = hwdata[15:0];
				`OFS_XEND: st_nxt.xe = hwdata[15:0];
				`OFS_YSTART: st_nxt.ys = hwdata[15:0];
				`OFS_YEND: st_nxt.ye = hwdata[15:0];
				default: st_nxt.wr_pend = 1'b0;
			endcase
		end
		st_nxt.wr_pend = take && hwrite && haddr[31:8] == 24'h000000;
		st_nxt.wofs = haddr[7:0];
		if (take && !hwrite && haddr[31:8] == 24'h000000) begin
			st_nxt.rdata = {16'h0000, rd_val(st_nxt, haddr[7:0], last_ea)};
		end else if (take) begin
			st_nxt.rdata = 32'h00000000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '{wr_pend: 1'b0, wofs: 8'h00, ctrl: `CTRL_RESET, xs: `BOUND_RESET,
				xe: `BOUND_RESET, ys: `BOUND_RESET, ye: `BOUND_RESET,
				rdata: 32'h00000000, rdy: 1'b1};
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign hrdata = st_r.rdata;
	assign hreadyout = st_r.rdy;
	assign hresp = 1'b0;
	assign ctrl = st_r.ctrl;
	assign xs = st_r.xs;
	assign xe = st_r.xe;
	assign ys = st_r.ys;
	assign ye = st_r.ye;
endmodule

// [bench/ea_core_model.sv]
// Purpose: working register file feeding the address unit pointers
// Assumes: write-backs land at the edge after valid
// Notes: bench presets pointers through setw between requests
`timescale 1ns/10ps
module ea_core_model (
	input wire logic hclk,
	input wire logic [3:0] a_idx,
	input wire logic [3:0] b_idx,
	input wire logic wa_en,
	input wire logic [15:0] wa_val,
	input wire logic wb_en,
	input wire logic [15:0] wb_val,
	output logic [15:0] a_ptr,
	output logic [15:0] b_ptr
);
	logic [15:0] w [16];

	// preset only when no write-back is pending, else the edge wins
	task setw(input logic [3:0] i, input logic [15:0] v);
		w[i] = v;
	endtask

	initial begin
		for (int i = 0; i < 16; i++) begin
			w[i] = 16'h0000;
		end
	end

	// pointers read out by index, the unit does its own routing
	assign a_ptr = w[a_idx];
	assign b_ptr = w[b_idx];

	// pointer only changes when the unit asks for it
	always @(posedge hclk) begin
		if (wa_en) begin
			w[a_idx] <= wa_val;
		end
		if (wb_en) begin
			w[b_idx] <= wb_val;
		end
	end
endmodule

// [bench/tb_effective_address_modulo_unit.sv]
// Purpose: self-checking bench for the address unit
// Assumes: zero wait state bus, results one cycle after req
// Notes: modulo never pointed at frame or stack pointer
`timescale 1ns/10ps
module tb_effective_address_modulo_unit import ea_unit_pkg::*;;
	logic hclk, hresetn, ce, hsel, hwrite, hready, req, file_to_default_working_register;
	logic [1:0] htrans, mac_step;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic hreadyout, hresp, valid, fault, wa_en, wb_en, dest_reg;
	logic [3:0] a_idx, b_idx;
	logic [15:0] a_ptr, b_ptr, off_val, lit, step, ea_a, ea_b, wa_val, wb_val, opnd, ov;
	op_class_t op_class;
	addr_mode_t a_mode, b_mode;
	logic s_fault, s_wa, s_wb, s_dest;
	int error_cnt, checked;

	assign hready = hreadyout;

	ea_modulo_unit dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.htrans(htrans), .haddr(haddr), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .req(req),
		.op_class(op_class), .a_mode(a_mode), .a_idx(a_idx), .a_ptr(a_ptr),
		.b_mode(b_mode), .b_idx(b_idx), .b_ptr(b_ptr), .off_val(off_val), .lit(lit),
		.step(step), .mac_step(mac_step), .file_to_default_working_register(file_to_default_working_register), .valid(valid),
		.fault(fault), .ea_a(ea_a), .ea_b(ea_b), .wa_en(wa_en), .wa_val(wa_val),
		.wb_en(wb_en), .wb_val(wb_val), .dest_reg(dest_reg), .opnd(opnd));

	ea_core_model core (.hclk(hclk), .a_idx(a_idx), .b_idx(b_idx), .wa_en(wa_en),
		.wa_val(wa_val), .wb_en(wb_en), .wb_val(wb_val), .a_ptr(a_ptr), .b_ptr(b_ptr));

	// 100 MHz clock
	initial begin
		hclk = 1'h0;
		forever #5 hclk = ~hclk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask

	task summarize;
		$display("mismatches %0d comparisons %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// one single word transfer, read data taken at the data phase edge
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'h1);
		rd = hrdata;
	endtask

	// one core request; pulses captured, returns once write-back landed
	task op(input op_class_t c, input addr_mode_t am, input logic [3:0] ai,
		input addr_mode_t bm, input logic [3:0] bi, input logic [15:0] lt,
		input logic [15:0] st, input logic [1:0] ms);
		@(posedge hclk);
		req <= 1'h1;
		op_class <= c;
		a_mode <= am;
		a_idx <= ai;
		b_mode <= bm;
		b_idx <= bi;
		lit <= lt;
		step <= st;
		mac_step <= ms;
		off_val <= ov;
		file_to_default_working_register <= (c == CLS_FILE);
		@(posedge hclk);
		req <= 1'h0;
		#1;
		chk(valid, 1'h1);
		s_fault = fault;
		s_wa = wa_en;
		s_wb = wb_en;
		s_dest = dest_reg;
		@(posedge hclk);
		#1;
		chk(valid, 1'h0);
	endtask

	// reset values, unmapped place, 16-bit bounds
	task t_regs;
		bus(1'h0, 32'h00, 32'h0);
		chk(rd, 32'h000000ff);
		bus(1'h0, 32'h08, 32'h0);
		chk(rd, 32'h0);
		bus(1'h1, 32'h20, 32'h1234);
		bus(1'h0, 32'h20, 32'h0);
		chk(rd, 32'h0);
		bus(1'h1, 32'h04, 32'hffffabcd);
		bus(1'h0, 32'h04, 32'h0);
		chk(rd, 32'h0000abcd);
		chk(hresp, 1'h0);
	endtask

	task t_file;
		op(CLS_FILE, AM_DIRECT, 4'h3, AM_DIRECT, 4'h3, 16'hffff, 16'h0, 2'h0);
		chk(ea_a, 16'h1fff);
		chk(s_dest, 1'h1);
		chk(ea_b, 16'h0000);
		chk(s_wa, 1'h0);
	endtask

	// modulo off: every plain mode and the shared offset
	task t_modes;
		core.setw(4'h1, 16'h1000);
		core.setw(4'h2, 16'h2000);
		ov = 16'h0010;
		op(CLS_MOVE, AM_IND, 4'h1, AM_DIRECT, 4'h2, 16'h0, 16'h0, 2'h0);
		chk(ea_a, 16'h1000);
		chk(s_wa, 1'h0);
		op(CLS_MOVE, AM_POST, 4'h1, AM_DIRECT, 4'h2, 16'h0, 16'h0002, 2'h0);
		chk(ea_a, 16'h1000);
		chk(wa_val, 16'h1002);
		chk(s_wa, 1'h1);
		op(CLS_MOVE, AM_PRE, 4'h1, AM_DIRECT, 4'h2, 16'h0, 16'hfffc, 2'h0);
		chk(ea_a, 16'h0ffe);
		chk(wa_val, 16'h0ffe);
		op(CLS_MOVE, AM_LITOFF, 4'h1, AM_DIRECT, 4'h2, 16'h0020, 16'h0, 2'h0);
		chk(ea_a, 16'h101e);
		op(CLS_MOVE, AM_INDEX, 4'h1, AM_INDEX, 4'h2, 16'h0, 16'h0, 2'h0);
		chk(ea_a, 16'h100e);
		chk(ea_b, 16'h2010);
		chk(s_wa | s_wb, 1'h0);
	endtask

	task t_mcu;
		op(CLS_MCU, AM_LIT, 4'h3, AM_DIRECT, 4'h4, 16'hfff5, 16'h0, 2'h0);
		chk(s_fault, 1'h0);
		chk(opnd, 16'h0015);
		op(CLS_MCU, AM_IND, 4'h3, AM_IND, 4'h4, 16'h0, 16'h0, 2'h0);
		chk(s_fault, 1'h1);
		op(CLS_BRA, AM_LIT, 4'h0, AM_DIRECT, 4'h0, 16'h8000, 16'h0, 2'h0);
		chk(opnd, 16'h8000);
		op(CLS_INTERRUPT_DISABLE_OPERATION, AM_LIT, 4'h0, AM_DIRECT, 4'h0, 16'hffff, 16'h0, 2'h0);
		chk(opnd, 16'h3fff);
	endtask

	task t_mac;
		for (int m = 1; m < 4; m++) begin
			core.setw(4'h8, 16'h0800);
			op(CLS_MAC, AM_POST, 4'h8, AM_IND, 4'ha, 16'h0, 16'h0, m[1:0]);
			chk(wa_val, 32'h0800 + 2 * m);
		end
		core.setw(4'h9, 16'h0900);
		ov = 16'h0004;
		op(CLS_MAC, AM_INDEX, 4'h9, AM_INDEX, 4'hb, 16'h0, 16'h0, 2'h0);
		chk({s_fault, ea_a}, {1'h0, 16'h0904});
		op(CLS_MAC, AM_INDEX, 4'h8, AM_IND, 4'ha, 16'h0, 16'h0, 2'h0);
		chk(s_fault, 1'h1);
		op(CLS_MAC, AM_IND, 4'h7, AM_IND, 4'ha, 16'h0, 16'h0, 2'h0);
		chk(s_fault, 1'h1);
		op(CLS_MAC, AM_IND, 4'h8, AM_IND, 4'hc, 16'h0, 16'h0, 2'h0);
		chk(s_fault, 1'h1);
		op(CLS_MAC, AM_POST, 4'h8, AM_IND, 4'ha, 16'h0, 16'h0, 2'h0);
		chk({s_fault, s_wa}, 2'h2);
	endtask

	// x buffer 0x1100..0x1163 is not a power of two: only the bound it runs toward
	task t_circ;
		bus(1'h1, 32'h04, 32'h1100);
		bus(1'h1, 32'h08, 32'h1163);
		bus(1'h1, 32'h00, 32'h8001);
		core.setw(4'h1, 16'h1162);
		op(CLS_MOVE, AM_POST, 4'h1, AM_DIRECT, 4'h2, 16'h0, 16'h0002, 2'h0);
		chk({ea_a, wa_val}, {16'h1162, 16'h1100});
		core.setw(4'h1, 16'h1162);
		op(CLS_MOVE, AM_POST, 4'h1, AM_DIRECT, 4'h2, 16'h0, 16'h0006, 2'h0);
		chk(wa_val, 16'h1104);
		core.setw(4'h1, 16'h1160);
		op(CLS_MOVE, AM_POST, 4'h1, AM_DIRECT, 4'h2, 16'h0, 16'h0002, 2'h0);
		chk(wa_val, 16'h1162);
		op(CLS_MOVE, AM_LITOFF, 4'h1, AM_DIRECT, 4'h2, 16'h0006, 16'h0, 2'h0);
		chk({ea_a, 15'h0, s_wa}, {16'h1104, 16'h0});
		core.setw(4'h1, 16'h1100);
		op(CLS_MOVE, AM_POST, 4'h1, AM_DIRECT, 4'h2, 16'h0, 16'hfffe, 2'h0);
		chk(wa_val, 16'h1162);
		bus(1'h1, 32'h00, 32'h0001);
		core.setw(4'h1, 16'h1162);
		op(CLS_MOVE, AM_POST, 4'h1, AM_DIRECT, 4'h2, 16'h0, 16'h0002, 2'h0);
		chk(wa_val, 16'h1164);
		bus(1'h1, 32'h04, 32'h1200);
		bus(1'h1, 32'h08, 32'h123f);
		bus(1'h1, 32'h00, 32'h8001);
		core.setw(4'h1, 16'h1200);
		op(CLS_MOVE, AM_PRE, 4'h1, AM_DIRECT, 4'h2, 16'h0, 16'hfffe, 2'h0);
		chk({ea_a, wa_val}, {16'h123e, 16'h123e});
		op(CLS_MOVE, AM_PRE, 4'h1, AM_DIRECT, 4'h2, 16'h0, 16'h0002, 2'h0);
		chk({ea_a, wa_val}, {16'h1200, 16'h1200});
		bus(1'h1, 32'h0c, 32'h1800);
		bus(1'h1, 32'h10, 32'h1803);
		bus(1'h0, 32'h10, 32'h0);
		chk(rd, 32'h1803);
		bus(1'h1, 32'h00, 32'h40af);
		core.setw(4'ha, 16'h1802);
		op(CLS_MAC, AM_IND, 4'h8, AM_POST, 4'ha, 16'h0, 16'h0, 2'h1);
		chk({s_wb, wb_val}, {1'h1, 16'h1800});
		bus(1'h1, 32'h00, 32'h00af);
		core.setw(4'ha, 16'h1802);
		op(CLS_MAC, AM_IND, 4'h8, AM_POST, 4'ha, 16'h0, 16'h0, 2'h1);
		chk(wb_val, 16'h1804);
	endtask

	initial begin
		#100000;
		error_cnt++;
		summarize();
	end

	initial begin
		error_cnt = 0;
		checked = 0;
		hresetn = 1'h0;
		ce = 1'h1;
		hsel = 1'h1;
		hsize = 3'h2;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'h0;
		hwdata = 32'h0;
		req = 1'h0;
		op_class = CLS_FILE;
		a_mode = AM_DIRECT;
		b_mode = AM_DIRECT;
		a_idx = 4'h0;
		b_idx = 4'h0;
		off_val = 16'h0;
		ov = 16'h0;
		lit = 16'h0;
		step = 16'h0;
		mac_step = 2'h0;
		file_to_default_working_register = 1'h0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'h1;
		t_regs();
		t_file();
		t_modes();
		t_mcu();
		t_mac();
		t_circ();
		summarize();
	end
endmodule
